// [rtl/sys_ctl_regs.svh]
/*
 State counts, steps, write-back mask bits and reset values.
 Assumes inclusion by bare name.
*/
// Notes on behaviour
// - trap pushes PC then CONDITION_CODE_REG pre-decrement, loads vector, 14 or 16 states.
// - exception return pops CONDITION_CODE_REG then PC post-increment, restoring all flags.
// - sleep enters power-down, flags kept, 2 states.
// - load CONDITION_CODE_REG post-increment reads word at source pointer, then pointer plus 2.
// - store CONDITION_CODE_REG pre-decrement subtracts 2 from destination pointer, then writes.
// - store CONDITION_CODE_REG with 16-bit displacement takes 8 states, flags kept.
// - byte block move repeats while low count byte nonzero, flags kept.
// - word block move repeats while full 16-bit count nonzero, flags kept.
// - block move takes 8 states plus 4 per unit counted.
// - state counts hold for on-chip operands; slower memory adds states.
// - transfers tied to the slow peripheral clock take a variable count.
`ifndef SYS_CTL_REGS_SVH
`define SYS_CTL_REGS_SVH

`define SC_ST_W 20
`define ST_TRAP_NORMAL 20'h0000E
`define ST_TRAP_ADV 20'h00010
`define ST_RTE 20'h0000A
`define ST_SHORT 20'h00002
`define ST_MEM_IND 20'h00006
`define ST_MEM_D16 20'h00008
`define ST_MEM_D24 20'h0000C
`define ST_MEM_AUTO 20'h00008
`define ST_MEM_ABS16 20'h00008
`define ST_MEM_ABS24 20'h0000A
`define ST_MOVE_BASE 20'h00008
`define ST_MOVE_UNIT 20'h00004

`define PTR_STEP 32'h00000002
`define PC_STEP 32'h00000002
`define BYTE_STEP 32'h00000001

`define WB_W 7
`define WB_CCR 0
`define WB_PC 1
`define WB_SP 2
`define WB_SRC 3
`define WB_DST 4
`define WB_COUNT 5
`define WB_REG8 6

`define CCR_RESET 8'h00
`define WORD_RESET 32'h00000000

`endif

// [rtl/sys_ctl_pkg.sv]
/*
 Types of the execution unit.
 Assumes nothing of its surroundings.
*/
package sys_ctl_pkg;
   typedef enum logic [3:0] {
      OP_NOP, OP_SLEEP, OP_TRAP, OP_RTE, OP_LDC_IMM, OP_LDC_REG, OP_LDC_MEM,
      OP_STC_REG, OP_STC_MEM, OP_CONTROL_AND_IMMEDIATE, OP_ORC, OP_CONTROL_XOR_IMMEDIATE, OP_MOVE_B, OP_MOVE_W
   } instr_t;

   typedef enum logic [2:0] {
      EA_IND, EA_DISP16, EA_DISP24, EA_AUTO, EA_ABS16, EA_ABS24
   } ea_mode_t;

   typedef enum logic [3:0] {
      S_IDLE, S_PUSH_PC_LO, S_PUSH_PC_HI, S_PUSH_CCR, S_POP_CCR, S_POP_PC_HI, S_POP_PC_LO,
      S_LOAD, S_STORE, S_MOVE_RD, S_MOVE_WR, S_PAD
   } exec_state_t;
endpackage

// [rtl/sys_ctl_state_count.sv]
/*
 Nominal state count of one instruction, on-chip.
 Assumes stable operands.
*/
`timescale 1ns/1ps
`include "sys_ctl_regs.svh"
module sys_ctl_state_count #(
   parameter int COUNT_W = 16
) (
   input wire sys_ctl_pkg::instr_t op,
   input wire sys_ctl_pkg::ea_mode_t mode,
   input wire logic advanced,
   input wire logic [COUNT_W-1:0] count,
   output logic [`SC_ST_W-1:0] states
);
   logic [`SC_ST_W-1:0] units;

   always_comb begin
      units = '0;
      if (op == sys_ctl_pkg::OP_MOVE_W) begin
         units = `SC_ST_W'(count);
      end else begin
         units = `SC_ST_W'(count[7:0]);
      end
   end

   always_comb begin
      states = `ST_SHORT;
      case (op)
         sys_ctl_pkg::OP_TRAP: states = advanced ? `ST_TRAP_ADV : `ST_TRAP_NORMAL;
         sys_ctl_pkg::OP_RTE: states = `ST_RTE;
         sys_ctl_pkg::OP_LDC_MEM, sys_ctl_pkg::OP_STC_MEM: begin
            case (mode)
               sys_ctl_pkg::EA_IND: states = `ST_MEM_IND;
               sys_ctl_pkg::EA_DISP16: states = `ST_MEM_D16;
               sys_ctl_pkg::EA_DISP24: states = `ST_MEM_D24;
               sys_ctl_pkg::EA_AUTO: states = `ST_MEM_AUTO;
               sys_ctl_pkg::EA_ABS16: states = `ST_MEM_ABS16;
               default: states = `ST_MEM_ABS24;
            endcase
         end
         sys_ctl_pkg::OP_MOVE_B, sys_ctl_pkg::OP_MOVE_W: begin
            states = `ST_MOVE_BASE + `SC_ST_W'(units * `ST_MOVE_UNIT);
         end
         default: states = `ST_SHORT;
      endcase
   end
endmodule

// [rtl/sys_ctl_mem_port.sv]
/*
 One memory access: go latches it, request held until acknowledged.
 Assumes no go while an access is open.
*/
`timescale 1ns/1ps
module sys_ctl_mem_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic we,
   input wire logic byte_acc,
   input wire logic [31:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   output logic mem_req,
   output logic mem_we,
   output logic mem_byte,
   output logic [31:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack
);
   // completion is combinational so each access costs two states on-chip
   assign done = mem_req & mem_ack;
   assign rdata = mem_rdata;

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_req <= 1'b0;
      end else if (go) begin
         mem_req <= 1'b1;
      end else if (done) begin
         mem_req <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_we <= 1'b0;
         mem_byte <= 1'b0;
         mem_addr <= 32'h00000000;
         mem_wdata <= 16'h0000;
      end else if (go) begin
         mem_we <= we;
         mem_byte <= byte_acc;
         mem_addr <= addr;
         mem_wdata <= wdata;
      end
   end
endmodule

// [rtl/sys_ctl_exec.sv]
/*
 Execution unit for system control and block move instructions.
 Assumes one instruction per START while BUSY is low; results
 are written back per WB_MASK at DONE.
*/
`timescale 1ns/1ps
`include "sys_ctl_regs.svh"
module sys_ctl_exec #(
   parameter int COUNT_W = 16
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic START,
   input wire sys_ctl_pkg::instr_t OPCODE,
   input wire sys_ctl_pkg::ea_mode_t EA_MODE,
   input wire logic ADVANCED,
   input wire logic [7:0] IMM8,
   input wire logic [31:0] DISP,
   input wire logic [31:0] ABS_ADDR,
   input wire logic [7:0] SRC_REG8,
   input wire logic [7:0] CCR_IN,
   input wire logic [31:0] PC_IN,
   input wire logic [31:0] SP_IN,
   input wire logic [31:0] SRC_PTR_IN,
   input wire logic [31:0] DST_PTR_IN,
   input wire logic [COUNT_W-1:0] COUNT_IN,
   input wire logic [31:0] TRAP_VECTOR,
   input wire logic WAKE,
   output logic MEM_REQ,
   output logic MEM_WE,
   output logic MEM_BYTE,
   output logic [31:0] MEM_ADDR,
   output logic [15:0] MEM_WDATA,
   input wire logic [15:0] MEM_RDATA,
   input wire logic MEM_ACK,
   output logic BUSY,
   output logic DONE,
   output logic [`WB_W-1:0] WB_MASK,
   output logic [7:0] CCR_OUT,
   output logic [31:0] PC_OUT,
   output logic [31:0] SP_OUT,
   output logic [31:0] SRC_PTR_OUT,
   output logic [31:0] DST_PTR_OUT,
   output logic [COUNT_W-1:0] COUNT_OUT,
   output logic [7:0] REG8_OUT,
   output logic [`SC_ST_W-1:0] STATE_COUNT,
   output logic POWER_DOWN
);
   if (COUNT_W < 8 || COUNT_W > 16) begin : g_bad_count_w
      $error("COUNT_W must lie between 8 and 16");
   end

   sys_ctl_pkg::exec_state_t state;
   sys_ctl_pkg::instr_t op;
   sys_ctl_pkg::ea_mode_t mode;
   logic adv;
   logic issued;
   logic [`SC_ST_W-1:0] elapsed;
   logic [`SC_ST_W-1:0] base;
   logic [`SC_ST_W-1:0] next_base;
   logic [31:0] ea;
   logic [31:0] vector;
   logic [7:0] move_byte;
   logic [31:0] ea_ptr;
   logic go;
   logic acc_we;
   logic acc_byte;
   logic [31:0] acc_addr;
   logic [15:0] acc_wdata;
   logic acc_done;
   logic [15:0] acc_rdata;
   logic take;

   function automatic logic [31:0] ea_calc(input sys_ctl_pkg::ea_mode_t m, input logic [31:0] ptr,
                                           input logic [31:0] disp, input logic [31:0] abs_a);
      case (m)
         sys_ctl_pkg::EA_DISP16: ea_calc = ptr + {{16{disp[15]}}, disp[15:0]};
         sys_ctl_pkg::EA_DISP24: ea_calc = ptr + {{8{disp[23]}}, disp[23:0]};
         sys_ctl_pkg::EA_ABS16: ea_calc = {{16{abs_a[15]}}, abs_a[15:0]};
         sys_ctl_pkg::EA_ABS24: ea_calc = {8'h00, abs_a[23:0]};
         default: ea_calc = ptr;
      endcase
   endfunction

   // byte moves look only at the low count byte, word moves at all of it
   function automatic logic count_live(input logic [COUNT_W-1:0] cnt, input logic word_mode);
      if (word_mode) begin
         count_live = (cnt != '0);
      end else begin
         count_live = (cnt[7:0] != 8'h00);
      end
   endfunction

   function automatic logic [COUNT_W-1:0] count_dec(input logic [COUNT_W-1:0] cnt, input logic word_mode);
      logic [COUNT_W-1:0] res;
      res = cnt;
      if (word_mode) begin
         res = cnt - COUNT_W'(1);
      end else begin
         res[7:0] = cnt[7:0] - 8'h01;
      end
      count_dec = res;
   endfunction

   assign take = START && (state == sys_ctl_pkg::S_IDLE) && !POWER_DOWN;
   assign BUSY = (state != sys_ctl_pkg::S_IDLE);

   sys_ctl_state_count #(
      .COUNT_W(COUNT_W)
   ) u_count (
      .op(OPCODE),
      .mode(EA_MODE),
      .advanced(ADVANCED),
      .count(COUNT_IN),
      .states(next_base)
   );

   always_comb begin
      if (OPCODE == sys_ctl_pkg::OP_STC_MEM) begin
         if (EA_MODE == sys_ctl_pkg::EA_AUTO) begin
            ea_ptr = DST_PTR_IN - `PTR_STEP;
         end else begin
            ea_ptr = DST_PTR_IN;
         end
      end else begin
         ea_ptr = SRC_PTR_IN;
      end
   end

   // address and data of the access that the current state needs
   always_comb begin
      acc_we = 1'b0;
      acc_byte = 1'b0;
      acc_addr = SP_OUT;
      acc_wdata = 16'h0000;
      case (state)
         sys_ctl_pkg::S_PUSH_PC_LO: begin
            acc_we = 1'b1;
            acc_addr = SP_OUT - `PTR_STEP;
            acc_wdata = PC_OUT[15:0];
         end
         sys_ctl_pkg::S_PUSH_PC_HI: begin
            acc_we = 1'b1;
            acc_addr = SP_OUT - `PTR_STEP;
            acc_wdata = PC_OUT[31:16];
         end
         sys_ctl_pkg::S_PUSH_CCR: begin
            acc_we = 1'b1;
            acc_addr = SP_OUT - `PTR_STEP;
            acc_wdata = {CCR_OUT, CCR_OUT};
         end
         sys_ctl_pkg::S_LOAD: acc_addr = ea;
         sys_ctl_pkg::S_STORE: begin
            acc_we = 1'b1;
            acc_addr = ea;
            acc_wdata = {CCR_OUT, CCR_OUT};
         end
         sys_ctl_pkg::S_MOVE_RD: begin
            acc_byte = 1'b1;
            acc_addr = SRC_PTR_OUT;
         end
         sys_ctl_pkg::S_MOVE_WR: begin
            acc_we = 1'b1;
            acc_byte = 1'b1;
            acc_addr = DST_PTR_OUT;
            acc_wdata = {8'h00, move_byte};
         end
         default: acc_addr = SP_OUT;
      endcase
   end

   assign go = !issued && (state != sys_ctl_pkg::S_IDLE) && (state != sys_ctl_pkg::S_PAD);

   sys_ctl_mem_port u_mem (
      .clk(CLK),
      .rst(SYS_RST),
      .go(go),
      .we(acc_we),
      .byte_acc(acc_byte),
      .addr(acc_addr),
      .wdata(acc_wdata),
      .done(acc_done),
      .rdata(acc_rdata),
      .mem_req(MEM_REQ),
      .mem_we(MEM_WE),
      .mem_byte(MEM_BYTE),
      .mem_addr(MEM_ADDR),
      .mem_wdata(MEM_WDATA),
      .mem_rdata(MEM_RDATA),
      .mem_ack(MEM_ACK)
   );

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         issued <= 1'b0;
      end else if (go) begin
         issued <= 1'b1;
      end else if (acc_done) begin
         issued <= 1'b0;
      end
   end

   // states since START; memory waits beyond on-chip speed stretch it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         elapsed <= '0;
      end else if (take) begin
         elapsed <= `SC_ST_W'(1);
      end else if (BUSY && elapsed != '1) begin
         elapsed <= elapsed + `SC_ST_W'(1);
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         op <= sys_ctl_pkg::OP_NOP;
         mode <= sys_ctl_pkg::EA_IND;
         adv <= 1'b0;
         base <= '0;
         ea <= `WORD_RESET;
         vector <= `WORD_RESET;
      end else if (take) begin
         op <= OPCODE;
         mode <= EA_MODE;
         adv <= ADVANCED;
         base <= next_base;
         ea <= ea_calc(EA_MODE, ea_ptr, DISP, ABS_ADDR);
         vector <= TRAP_VECTOR;
      end else if (MEM_REQ && !MEM_ACK) begin
         base <= base + `SC_ST_W'(1);
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state <= sys_ctl_pkg::S_IDLE;
      end else begin
         case (state)
            sys_ctl_pkg::S_IDLE: begin
               if (take) begin
                  case (OPCODE)
                     sys_ctl_pkg::OP_TRAP: state <= sys_ctl_pkg::S_PUSH_PC_LO;
                     sys_ctl_pkg::OP_RTE: state <= sys_ctl_pkg::S_POP_CCR;
                     sys_ctl_pkg::OP_LDC_MEM: state <= sys_ctl_pkg::S_LOAD;
                     sys_ctl_pkg::OP_STC_MEM: state <= sys_ctl_pkg::S_STORE;
                     sys_ctl_pkg::OP_MOVE_B, sys_ctl_pkg::OP_MOVE_W: begin
                        if (count_live(COUNT_IN, OPCODE == sys_ctl_pkg::OP_MOVE_W)) begin
                           state <= sys_ctl_pkg::S_MOVE_RD;
                        end else begin
                           state <= sys_ctl_pkg::S_PAD;
                        end
                     end
                     default: state <= sys_ctl_pkg::S_PAD;
                  endcase
               end
            end
            sys_ctl_pkg::S_PUSH_PC_LO: begin
               if (acc_done) begin
                  state <= adv ? sys_ctl_pkg::S_PUSH_PC_HI : sys_ctl_pkg::S_PUSH_CCR;
               end
            end
            sys_ctl_pkg::S_PUSH_PC_HI: begin
               if (acc_done) begin
                  state <= sys_ctl_pkg::S_PUSH_CCR;
               end
            end
            sys_ctl_pkg::S_POP_CCR: begin
               if (acc_done) begin
                  state <= adv ? sys_ctl_pkg::S_POP_PC_HI : sys_ctl_pkg::S_POP_PC_LO;
               end
            end
            sys_ctl_pkg::S_POP_PC_HI: begin
               if (acc_done) begin
                  state <= sys_ctl_pkg::S_POP_PC_LO;
               end
            end
            sys_ctl_pkg::S_MOVE_RD: begin
               if (acc_done) begin
                  state <= sys_ctl_pkg::S_MOVE_WR;
               end
            end
            sys_ctl_pkg::S_MOVE_WR: begin
               if (acc_done) begin
                  if (count_live(count_dec(COUNT_OUT, op == sys_ctl_pkg::OP_MOVE_W), op == sys_ctl_pkg::OP_MOVE_W)) begin
                     state <= sys_ctl_pkg::S_MOVE_RD;
                  end else begin
                     state <= sys_ctl_pkg::S_PAD;
                  end
               end
            end
            sys_ctl_pkg::S_PAD: begin
               if (elapsed >= base) begin
                  state <= sys_ctl_pkg::S_IDLE;
               end
            end
            default: begin
               if (acc_done) begin
                  state <= sys_ctl_pkg::S_PAD;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         DONE <= 1'b0;
         STATE_COUNT <= '0;
      end else begin
         DONE <= (state == sys_ctl_pkg::S_PAD) && (elapsed >= base);
         if ((state == sys_ctl_pkg::S_PAD) && (elapsed >= base)) begin
            STATE_COUNT <= elapsed;
         end
      end
   end

   // power-down follows completion of the sleep instruction
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         POWER_DOWN <= 1'b0;
      end else if ((state == sys_ctl_pkg::S_PAD) && (elapsed >= base) && (op == sys_ctl_pkg::OP_SLEEP)) begin
         POWER_DOWN <= 1'b1;
      end else if (WAKE) begin
         POWER_DOWN <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         CCR_OUT <= `CCR_RESET;
         REG8_OUT <= 8'h00;
         WB_MASK <= '0;
      end else if (take) begin
         CCR_OUT <= CCR_IN;
         REG8_OUT <= CCR_IN;
         WB_MASK <= '0;
         case (OPCODE)
            sys_ctl_pkg::OP_LDC_IMM: begin
               CCR_OUT <= IMM8;
               WB_MASK[`WB_CCR] <= 1'b1;
            end
            sys_ctl_pkg::OP_LDC_REG: begin
               CCR_OUT <= SRC_REG8;
               WB_MASK[`WB_CCR] <= 1'b1;
            end
            sys_ctl_pkg::OP_CONTROL_AND_IMMEDIATE: begin
               CCR_OUT <= CCR_IN & IMM8;
               WB_MASK[`WB_CCR] <= 1'b1;
            end
            sys_ctl_pkg::OP_ORC: begin
               CCR_OUT <= CCR_IN | IMM8;
               WB_MASK[`WB_CCR] <= 1'b1;
            end
            sys_ctl_pkg::OP_CONTROL_XOR_IMMEDIATE: begin
               CCR_OUT <= CCR_IN ^ IMM8;
               WB_MASK[`WB_CCR] <= 1'b1;
            end
            sys_ctl_pkg::OP_STC_REG: WB_MASK[`WB_REG8] <= 1'b1;
            sys_ctl_pkg::OP_TRAP: WB_MASK <= `WB_W'((1 << `WB_PC) | (1 << `WB_SP));
            sys_ctl_pkg::OP_RTE: WB_MASK <= `WB_W'((1 << `WB_CCR) | (1 << `WB_PC) | (1 << `WB_SP));
            sys_ctl_pkg::OP_LDC_MEM: begin
               WB_MASK[`WB_CCR] <= 1'b1;
               WB_MASK[`WB_SRC] <= (EA_MODE == sys_ctl_pkg::EA_AUTO);
            end
            sys_ctl_pkg::OP_STC_MEM: WB_MASK[`WB_DST] <= (EA_MODE == sys_ctl_pkg::EA_AUTO);
            sys_ctl_pkg::OP_MOVE_B, sys_ctl_pkg::OP_MOVE_W: begin
               WB_MASK <= `WB_W'((1 << `WB_SRC) | (1 << `WB_DST) | (1 << `WB_COUNT));
            end
            sys_ctl_pkg::OP_NOP: WB_MASK[`WB_PC] <= 1'b1;
            default: WB_MASK <= '0;
         endcase
      end else if (acc_done && (state == sys_ctl_pkg::S_POP_CCR || state == sys_ctl_pkg::S_LOAD)) begin
         CCR_OUT <= acc_rdata[15:8];
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         PC_OUT <= `WORD_RESET;
         SP_OUT <= `WORD_RESET;
      end else if (take) begin
         PC_OUT <= (OPCODE == sys_ctl_pkg::OP_NOP) ? PC_IN + `PC_STEP : PC_IN;
         SP_OUT <= SP_IN;
      end else if (acc_done) begin
         case (state)
            sys_ctl_pkg::S_PUSH_PC_LO, sys_ctl_pkg::S_PUSH_PC_HI: SP_OUT <= SP_OUT - `PTR_STEP;
            sys_ctl_pkg::S_PUSH_CCR: begin
               SP_OUT <= SP_OUT - `PTR_STEP;
               PC_OUT <= vector;
            end
            sys_ctl_pkg::S_POP_CCR: SP_OUT <= SP_OUT + `PTR_STEP;
            sys_ctl_pkg::S_POP_PC_HI: begin
               SP_OUT <= SP_OUT + `PTR_STEP;
               PC_OUT[31:16] <= acc_rdata;
            end
            sys_ctl_pkg::S_POP_PC_LO: begin
               SP_OUT <= SP_OUT + `PTR_STEP;
               PC_OUT <= {adv ? PC_OUT[31:16] : 16'h0000, acc_rdata};
            end
            default: SP_OUT <= SP_OUT;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         SRC_PTR_OUT <= `WORD_RESET;
         DST_PTR_OUT <= `WORD_RESET;
         COUNT_OUT <= '0;
         move_byte <= 8'h00;
      end else if (take) begin
         SRC_PTR_OUT <= SRC_PTR_IN;
         DST_PTR_OUT <= ea_ptr == SRC_PTR_IN && OPCODE != sys_ctl_pkg::OP_STC_MEM ? DST_PTR_IN : ea_ptr;
         COUNT_OUT <= COUNT_IN;
      end else if (acc_done) begin
         case (state)
            sys_ctl_pkg::S_LOAD: begin
               if (mode == sys_ctl_pkg::EA_AUTO) begin
                  SRC_PTR_OUT <= SRC_PTR_OUT + `PTR_STEP;
               end
            end
            sys_ctl_pkg::S_MOVE_RD: begin
               move_byte <= acc_rdata[7:0];
               SRC_PTR_OUT <= SRC_PTR_OUT + `BYTE_STEP;
            end
            sys_ctl_pkg::S_MOVE_WR: begin
               DST_PTR_OUT <= DST_PTR_OUT + `BYTE_STEP;
               COUNT_OUT <= count_dec(COUNT_OUT, op == sys_ctl_pkg::OP_MOVE_W);
            end
            default: move_byte <= move_byte;
         endcase
      end
   end
endmodule

// [tb/mem_model.sv]
/*
 Memory partner: byte array, answers after wait_n cycles.
 Assumes one request at a time.
*/
`timescale 1ns/1ps
module mem_model (
   input wire logic clk,
   input wire logic req,
   input wire logic we,
   input wire logic byte_acc,
   input wire logic [31:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   output logic ack,
   input wire logic [3:0] wait_n
);
   logic [7:0] mem [256];
   logic [3:0] cnt = 4'h0;
   logic [15:0] last = 16'h0000;
   wire [7:0] a = addr[7:0];
   // a nonzero wait_n holds every request for extra states
   assign ack = req && cnt >= wait_n;
   // no stale data outside an answer
   assign rdata = ack ? (byte_acc ? {8'h00, mem[a]} : {mem[a], mem[a + 8'h01]}) : ~last;
   always @(posedge clk) begin
      cnt <= (req && !ack) ? cnt + 4'h1 : 4'h0;
      if (ack)
         last <= rdata;
      if (ack && we && byte_acc)
         mem[a] <= wdata[7:0];
      if (ack && we && !byte_acc)
         {mem[a], mem[a + 8'h01]} <= wdata;
   end
endmodule

// [tb/sys_ctl_exec_checker.sv]
/*
 Assertions on the execution unit's ports.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sys_ctl_exec_checker (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic START,
   input wire sys_ctl_pkg::instr_t OPCODE,
   input wire logic ADVANCED,
   input wire logic WAKE,
   input wire logic [7:0] IMM8,
   input wire logic [7:0] CCR_IN,
   input wire logic [31:0] PC_IN,
   input wire logic MEM_REQ,
   input wire logic MEM_ACK,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic [7:0] CCR_OUT,
   input wire logic [31:0] PC_OUT,
   input wire logic [19:0] STATE_COUNT,
   input wire logic POWER_DOWN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire take = START && !BUSY && !POWER_DOWN;
   sys_ctl_pkg::instr_t op;
   logic adv;
   logic stall;
   logic [19:0] busy_n;
   always_ff @(posedge CLK) begin
      if (take) begin
         op <= OPCODE;
         adv <= ADVANCED;
      end
   end
   // busy cycles and memory waits of the running instruction
   always_ff @(posedge CLK) begin
      if (SYS_RST || take) begin
         stall <= 1'b0;
         busy_n <= 20'h00000;
      end else if (BUSY) begin
         stall <= stall || (MEM_REQ && !MEM_ACK);
         busy_n <= busy_n + 20'h00001;
      end
   end
   a_done_pulse: assert property (DONE |=> !DONE) else $error("done too long");
   a_state_actual: assert property (DONE |-> STATE_COUNT == busy_n) else $error("state count");
   a_trap_normal: assert property (DONE && !stall && op == sys_ctl_pkg::OP_TRAP && !adv
      |-> STATE_COUNT == 20'h0000E) else $error("trap normal states");
   a_trap_adv: assert property (DONE && !stall && op == sys_ctl_pkg::OP_TRAP && adv
      |-> STATE_COUNT == 20'h00010) else $error("trap advanced states");
   a_sleep_down: assert property (DONE && !WAKE && op == sys_ctl_pkg::OP_SLEEP
      |-> STATE_COUNT == 20'h00002 ##1 POWER_DOWN) else $error("sleep");
   a_short_ops: assert property (DONE && !stall && op inside {sys_ctl_pkg::OP_CONTROL_AND_IMMEDIATE, sys_ctl_pkg::OP_ORC,
      sys_ctl_pkg::OP_CONTROL_XOR_IMMEDIATE, sys_ctl_pkg::OP_NOP} |-> STATE_COUNT == 20'h00002) else $error("short op");
   a_nop_pc: assert property (take && OPCODE == sys_ctl_pkg::OP_NOP
      |-> ##3 (DONE && PC_OUT == $past(PC_IN, 3) + 32'h00000002)) else $error("nop pc");
   a_or_merge: assert property (take && OPCODE == sys_ctl_pkg::OP_ORC
      |-> ##3 (DONE && CCR_OUT == ($past(CCR_IN, 3) | $past(IMM8, 3)))) else $error("or result");
   a_asleep_idle: assert property (POWER_DOWN |=> !BUSY) else $error("start while asleep");
   c_trap_adv: cover property (DONE && op == sys_ctl_pkg::OP_TRAP && adv);
   c_stall: cover property (DONE && stall);
   c_sleep: cover property ($rose(POWER_DOWN));
endmodule
bind sys_ctl_exec sys_ctl_exec_checker chk (.*);

// [tb/testbench.sv]
/*
 Bench for the execution unit.
 Assumes mem_model answers after wait_n cycles.
*/
`timescale 1ns/1ps
module testbench;
   logic CLK = 1'b0, SYS_RST = 1'b1, START = 1'b0, ADVANCED = 1'b0, WAKE = 1'b0;
   sys_ctl_pkg::instr_t OPCODE = sys_ctl_pkg::OP_NOP;
   sys_ctl_pkg::ea_mode_t EA_MODE = sys_ctl_pkg::EA_AUTO;
   logic [7:0] IMM8 = 8'h00, SRC_REG8 = 8'h00, CCR_IN = 8'h00;
   logic [31:0] DISP = 32'h0, ABS_ADDR = 32'h0, PC_IN = 32'h0, SP_IN = 32'h0;
   logic [31:0] SRC_PTR_IN = 32'h0, DST_PTR_IN = 32'h0, TRAP_VECTOR = 32'h0;
   logic [15:0] COUNT_IN = 16'h0000;
   logic [3:0] wait_n = 4'h0;
   wire MEM_REQ, MEM_WE, MEM_BYTE, MEM_ACK, BUSY, DONE, POWER_DOWN;
   wire [31:0] MEM_ADDR, PC_OUT, SP_OUT, SRC_PTR_OUT, DST_PTR_OUT;
   wire [15:0] MEM_WDATA, MEM_RDATA, COUNT_OUT;
   wire [6:0] WB_MASK;
   wire [7:0] CCR_OUT, REG8_OUT;
   wire [19:0] STATE_COUNT;
   int fail_count = 0, comparisons = 0;
   always #12.5 CLK = ~CLK;
   sys_ctl_exec dut (.*);
   mem_model mdl (.clk(CLK), .req(MEM_REQ), .we(MEM_WE), .byte_acc(MEM_BYTE), .addr(MEM_ADDR),
      .wdata(MEM_WDATA), .rdata(MEM_RDATA), .ack(MEM_ACK), .wait_n(wait_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic issue(input sys_ctl_pkg::instr_t op);
      @(posedge CLK);
      OPCODE <= op;
      START <= 1'b1;
      @(posedge CLK);
      START <= 1'b0;
      for (int i = 0; i < 2000 && DONE !== 1'b1; i++) @(negedge CLK);
      chk(DONE, 1'b1);
   endtask
   task automatic t_short;
      sys_ctl_pkg::instr_t ops[4] = '{sys_ctl_pkg::OP_CONTROL_AND_IMMEDIATE, sys_ctl_pkg::OP_ORC, sys_ctl_pkg::OP_CONTROL_XOR_IMMEDIATE,
         sys_ctl_pkg::OP_LDC_IMM};
      logic [7:0] res[4] = '{8'h24, 8'hBD, 8'h99, 8'h3C};
      @(posedge CLK);
      PC_IN <= 32'h1000;
      CCR_IN <= 8'hA5;
      IMM8 <= 8'h3C;
      issue(sys_ctl_pkg::OP_NOP);
      chk(PC_OUT, 32'h1002);
      chk(WB_MASK, 7'h02);
      for (int k = 0; k < 4; k++) begin
         issue(ops[k]);
         chk(CCR_OUT, res[k]);
         chk(STATE_COUNT, 32'h2);
      end
      issue(sys_ctl_pkg::OP_STC_REG);
      chk({REG8_OUT, STATE_COUNT[7:0]}, 16'hA502);
   endtask
   task automatic t_trap;
      for (int m = 0; m < 2; m++) begin
         @(posedge CLK);
         ADVANCED <= m[0];
         SP_IN <= 32'h80;
         PC_IN <= 32'h12345678;
         CCR_IN <= 8'h5A;
         TRAP_VECTOR <= 32'h400;
         issue(sys_ctl_pkg::OP_TRAP);
         chk(PC_OUT, 32'h400);
         chk(SP_OUT, m ? 32'h7A : 32'h7C);
         chk({mdl.mem[8'h7E], mdl.mem[8'h7F]}, 32'h5678);
         chk({mdl.mem[m ? 8'h7A : 8'h7C], mdl.mem[m ? 8'h7B : 8'h7D]}, 32'h5A5A);
         chk(STATE_COUNT, m ? 32'h10 : 32'hE);
         chk(WB_MASK[0], 1'b0);
      end
   endtask
   task automatic t_rte;
      @(posedge CLK);
      SP_IN <= 32'h7A;
      CCR_IN <= 8'h00;
      issue(sys_ctl_pkg::OP_RTE);
      chk(CCR_OUT, 8'h5A);
      chk(PC_OUT, 32'h12345678);
      chk(SP_OUT, 32'h80);
   endtask
   task automatic t_ccr_mem;
      for (int w = 0; w < 3; w += 2) begin
         @(posedge CLK);
         wait_n <= w[3:0];
         SRC_PTR_IN <= 32'h20;
         mdl.mem[8'h20] = 8'hC3;
         issue(sys_ctl_pkg::OP_LDC_MEM);
         chk(CCR_OUT, 8'hC3);
         chk(SRC_PTR_OUT, 32'h22);
         chk(STATE_COUNT, 8 + w);
      end
      @(posedge CLK);
      wait_n <= 4'h0;
      DST_PTR_IN <= 32'h40;
      CCR_IN <= 8'h3C;
      issue(sys_ctl_pkg::OP_STC_MEM);
      chk(DST_PTR_OUT, 32'h3E);
      chk({mdl.mem[8'h3E], mdl.mem[8'h3F]}, 32'h3C3C);
      chk(WB_MASK[0], 1'b0);
      @(posedge CLK);
      EA_MODE <= sys_ctl_pkg::EA_DISP16;
      DISP <= 32'hFFF0;
      issue(sys_ctl_pkg::OP_STC_MEM);
      chk({mdl.mem[8'h30], mdl.mem[8'h31]}, 32'h3C3C);
      chk(STATE_COUNT, 32'h8);
   endtask
   task automatic t_move;
      @(posedge CLK);
      SRC_PTR_IN <= 32'h50;
      DST_PTR_IN <= 32'h60;
      COUNT_IN <= 16'h0103;
      for (int i = 0; i < 3; i++) mdl.mem[8'h50 + i[7:0]] = 8'hA0 + i[7:0];
      issue(sys_ctl_pkg::OP_MOVE_B);
      chk(STATE_COUNT, 32'h14);
      chk(mdl.mem[8'h62], 8'hA2);
      chk(COUNT_OUT, 16'h0100);
      chk(DST_PTR_OUT, 32'h63);
      @(posedge CLK);
      COUNT_IN <= 16'h0100;
      issue(sys_ctl_pkg::OP_MOVE_B);
      chk(STATE_COUNT, 32'h8);
      issue(sys_ctl_pkg::OP_MOVE_W);
      chk(STATE_COUNT, 32'h408);
      chk(WB_MASK[0], 1'b0);
   endtask
   task automatic t_sleep;
      issue(sys_ctl_pkg::OP_SLEEP);
      chk(STATE_COUNT, 32'h2);
      chk(WB_MASK[0], 1'b0);
      @(posedge CLK);
      OPCODE <= sys_ctl_pkg::OP_NOP;
      START <= 1'b1;
      repeat (3) @(posedge CLK);
      START <= 1'b0;
      @(negedge CLK);
      chk({POWER_DOWN, BUSY}, 2'b10);
      @(posedge CLK);
      WAKE <= 1'b1;
      @(posedge CLK);
      WAKE <= 1'b0;
      issue(sys_ctl_pkg::OP_NOP);
   endtask
   task automatic test_done;
      if (fail_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_short;
      t_trap;
      t_rte;
      t_ccr_mem;
      t_move;
      t_sleep;
      test_done;
   end
   initial begin
      repeat (4000) @(posedge CLK);
      fail_count++;
      test_done;
   end
endmodule
